// ---- rtl/smc_pkg.sv ----
package smc_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_TBC = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CPU = 8'h10;

    // Field positions.
    localparam int CTRL1_STOP_BIT = 0;
    localparam int TBC_SEL_LSB = 0;
    localparam int TBC_EN_BIT = 3;
    localparam int TBC_DV7_BIT = 4;
    localparam int CPU_IME_BIT = 0;
    localparam int CPU_TBIE_BIT = 1;
    localparam int ST_LATCH_BIT = 0;
    localparam int ST_MSTATE_LSB = 1;
    localparam int ST_MODE_LSB = 8;

    // Timing generator geometry.
    localparam int PRE_W = 2;
    localparam int LOW_W = 6;
    localparam int DIV_W = 21;
    localparam int HIGH_W = DIV_W - LOW_W;
    localparam logic [1:0] LAST_STATE = 2'h3;

    // Second control register fields, in bit order from the top.
    typedef struct packed {
        logic tg_stop;
        logic doze;
        logic main_clock_source_select;
        logic slow_osc_enable;
        logic fast_osc_enable;
    } smc_ctrl2_t;
    localparam smc_ctrl2_t CTRL2_RESET = 5'h01;

    // Time base control fields.
    typedef struct packed {
        logic divider_stage7_source;
        logic time_base_enable_bit;
        logic [2:0] time_base_source_select;
    } smc_tbc_t;
    localparam smc_tbc_t TBC_RESET = 5'h00;

    // Divider taps offered to the time base source select.
    localparam int TB_TAP [8] = '{20, 18, 15, 13, 11, 9, 8, 7};

    // Operating modes, one-hot.
    typedef enum logic [9:0] {
        M_SC_FAST = 10'h001,
        M_SC_DOZE = 10'h002,
        M_TB_DOZE = 10'h004,
        M_DC_FAST = 10'h008,
        M_DC_DOZE = 10'h010,
        M_SLOW_RUN_BOTH_OSC = 10'h020,
        M_SLOW_RUN_FAST_OSC_OFF = 10'h040,
        M_SLEEP = 10'h080,
        M_STOP = 10'h100,
        M_WARM = 10'h200
    } smc_mode_t;

endpackage

// ---- rtl/smc_system_clock_mode_controller.sv ----
// What this block does
// - Clocks come from a 2-stage prescaler, 21-stage divider and machine cycle counter.
// - Prescaler and divider clear on reset and on stop entry or exit.
// - Slow run and sleep feed the slow clock to stage seven.
// - Warm-up after a stop from fast run feeds stage six into stage seven.
// - A machine cycle is four states, each one main clock period.
// - Single-clock mode runs only the fast oscillator; slow crystal pins become ports.
// - Reset enters single-clock fast run.
// - Doze request enters single-clock doze; CPU and watchdog halt, peripherals run.
// - Any interrupt request ends single-clock doze back to fast run.
// - Waking with master enable set services the waking interrupt.
// - Waking with master enable clear resumes at the next instruction.
// - Timing-generator stop enters time-base-only doze; CPU, watchdog and peripherals halt, time base and main clock run.
// - A falling edge of the chosen time base tap ends that doze.
// - That doze ignores the enable; interrupt needs master, local and time base enables.
// - Entered with time base enabled, the interrupt latch sets after return.
// - Dual mode runs both oscillators; main clock fast or slow by mode.
// - In dual fast run the CPU runs fast; peripherals may use either clock.
// - Clock select one goes to slow run, zero back to dual fast run.
// - Clearing fast enable in slow run stops the fast oscillator.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module smc_system_clock_mode_controller
    import smc_pkg::*;
#(
    parameter int WARMUP_TICKS = 4096
)
(
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator ticks and wake sources.
    input wire logic fast_tick,
    input wire logic slow_tick,
    input wire logic irq_request,
    input wire logic stop_release,
    // Clock and run controls.
    output logic main_tick,
    output logic [1:0] machine_state,
    output logic [DIV_W-1:0] divider_value,
    output logic cpu_run,
    output logic watchdog_run,
    output logic periph_run,
    output logic fast_osc_on,
    output logic slow_osc_on,
    output logic slow_pins_as_port,
    // Wake outcomes.
    output logic irq_accept,
    output logic resume_next,
    output logic tb_irq_service
);

    // Last warm-up count; the exit waits for a tick so the full count elapses.
    localparam logic [11:0] WARM_LAST = 12'(WARMUP_TICKS - 1);

    // Mode, software and timing generator state.
    smc_mode_t mode_reg, mode_next;
    smc_ctrl2_t ctrl2_reg;
    smc_tbc_t tbc_reg;
    logic stop_req_reg;
    logic ime_reg, tbie_reg;
    logic tb_latch_reg;
    logic tben_entry_reg;
    logic warm_from_fast_reg;
    logic [11:0] warm_cnt_reg;
    logic [PRE_W-1:0] pre_reg;
    logic [LOW_W-1:0] low_reg;
    logic [HIGH_W-1:0] high_reg;
    logic [1:0] mstate_reg;
    logic use_slow_reg;
    logic tap_prev_reg;
    // Output registers; every port but machine_state and divider_value comes straight from one of these.
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic main_tick_reg, cpu_run_reg, wd_run_reg, periph_run_reg;
    logic fast_on_reg, slow_on_reg, port_reg;
    logic irq_accept_reg, resume_next_reg, tb_service_reg;

    // Bus decode.
    // A write commits in the access phase after the setup cycle.
    wire setup = psel & ~penable;
    wire wr_done = psel & penable & pready_reg & pwrite;
    wire hit_c1 = paddr == OFF_CTRL1;
    wire hit_c2 = paddr == OFF_CTRL2;
    wire hit_tbc = paddr == OFF_TBC;
    wire hit_st = paddr == OFF_STATUS;
    wire hit_cpu = paddr == OFF_CPU;
    wire mapped = hit_c1 | hit_c2 | hit_tbc | hit_st | hit_cpu;

    // Mode groups.
    wire in_slow = mode_reg inside {M_SLOW_RUN_FAST_OSC_OFF, M_SLOW_RUN_BOTH_OSC, M_SLEEP};
    wire in_doze = mode_reg inside {M_SC_DOZE, M_DC_DOZE, M_SLEEP};
    wire fast_mode = mode_reg inside {M_SC_FAST, M_DC_FAST};
    // Stop entry and exit both clear the timing generator.
    wire enter_stop = (mode_next == M_STOP) && (mode_reg != M_STOP);
    wire leave_stop = (mode_reg == M_STOP) && (mode_next != M_STOP);
    wire div_clear = enter_stop | leave_stop;

    // Divider chain: prescaler, stages one to six, stages seven on.
    wire fast_runs = fast_on_reg & ~(mode_reg inside {M_STOP, M_SLOW_RUN_FAST_OSC_OFF, M_SLEEP});
    wire pre_carry = fast_runs & fast_tick & (pre_reg == {PRE_W{1'b1}});
    wire low_carry = pre_carry & (low_reg == {LOW_W{1'b1}});
    // Stage seven takes the slow clock in slow modes and when divider_stage7_source selects it outside warm-up from fast run, the stage-six carry otherwise.
    // Selecting the slow clock in single-clock mode leaves stage seven idle.
    wire use_stage6 = (mode_reg == M_WARM && warm_from_fast_reg) || !tbc_reg.divider_stage7_source;
    wire stage7_in = in_slow ? slow_tick : (use_stage6 ? low_carry : slow_tick);
    wire [DIV_W-1:0] div_full = {high_reg, low_reg};

    // Time base tap and its falling edge.
    function automatic logic tap_of(input logic [DIV_W-1:0] d, input logic [2:0] s);
        tap_of = d[TB_TAP[s]];
    endfunction
    wire tap_now = tap_of(div_full, tbc_reg.time_base_source_select);
    // The edge register clears with the chain, so a clear never fakes an edge.
    wire tb_fall = tap_prev_reg & ~tap_now;

    // Main clock source; the switch waits for the end of state three.
    wire main_src = use_slow_reg ? slow_tick : fast_tick;
    wire main_go = main_src && !(mode_reg inside {M_STOP, M_WARM});
    wire cycle_end = main_go && (mstate_reg == LAST_STATE);
    // Switching at a cycle boundary keeps every state a full period long.
    wire want_slow = in_slow;

    // Mode transitions.
    // Run modes weigh stop, doze and clock requests in a fixed priority.
    always_comb
    begin
        mode_next = mode_reg;
        unique case (mode_reg)
            M_SC_FAST:
                if (stop_req_reg) mode_next = M_STOP;
                else if (ctrl2_reg.tg_stop) mode_next = M_TB_DOZE;
                else if (ctrl2_reg.doze) mode_next = M_SC_DOZE;
                else if (ctrl2_reg.slow_osc_enable) mode_next = M_DC_FAST;
            M_SC_DOZE:
                if (irq_request) mode_next = M_SC_FAST;
            M_TB_DOZE:
                if (tb_fall) mode_next = M_SC_FAST;
            M_DC_FAST:
                if (stop_req_reg) mode_next = M_STOP;
                else if (!ctrl2_reg.slow_osc_enable) mode_next = M_SC_FAST;
                else if (ctrl2_reg.main_clock_source_select) mode_next = M_SLOW_RUN_BOTH_OSC;
                else if (ctrl2_reg.doze) mode_next = M_DC_DOZE;
            M_DC_DOZE:
                if (irq_request) mode_next = M_DC_FAST;
            M_SLOW_RUN_BOTH_OSC:
                if (!ctrl2_reg.main_clock_source_select) mode_next = M_DC_FAST;
                else if (!ctrl2_reg.fast_osc_enable) mode_next = M_SLOW_RUN_FAST_OSC_OFF;
                else if (stop_req_reg) mode_next = M_STOP;
                else if (ctrl2_reg.doze) mode_next = M_SLEEP;
            M_SLOW_RUN_FAST_OSC_OFF:
                if (ctrl2_reg.fast_osc_enable) mode_next = M_SLOW_RUN_BOTH_OSC;
                else if (stop_req_reg) mode_next = M_STOP;
                else if (ctrl2_reg.doze) mode_next = M_SLEEP;
            // Sleep wakes to the slow run that matches the fast enable.
            M_SLEEP:
                if (irq_request) mode_next = ctrl2_reg.fast_osc_enable ? M_SLOW_RUN_BOTH_OSC : M_SLOW_RUN_FAST_OSC_OFF;
            M_STOP:
                if (stop_release) mode_next = M_WARM;
            M_WARM:
                if (warm_cnt_reg == WARM_LAST && fast_tick)
                begin
                    if (!warm_from_fast_reg) mode_next = ctrl2_reg.fast_osc_enable ? M_SLOW_RUN_BOTH_OSC : M_SLOW_RUN_FAST_OSC_OFF;
                    else if (ctrl2_reg.slow_osc_enable) mode_next = M_DC_FAST;
                    else mode_next = M_SC_FAST;
                end
            default:
                mode_next = M_SC_FAST;
        endcase
    end

    // Wake outcomes and run enables for the next mode.
    // Wake pulses come at the same edge as the mode leaves a doze.
    wire waking = in_doze && mode_next != mode_reg;
    wire tb_waking = mode_reg == M_TB_DOZE && mode_next == M_SC_FAST;
    wire next_cpu = mode_next inside {M_SC_FAST, M_DC_FAST, M_SLOW_RUN_BOTH_OSC, M_SLOW_RUN_FAST_OSC_OFF};
    wire next_periph = !(mode_next inside {M_TB_DOZE, M_STOP, M_WARM});
    wire next_fast = !(mode_next inside {M_SLOW_RUN_FAST_OSC_OFF, M_SLEEP, M_STOP});
    wire next_slow = !(mode_next inside {M_SC_FAST, M_SC_DOZE, M_TB_DOZE}) && ctrl2_reg.slow_osc_enable;
    wire latch_set = tb_waking && tben_entry_reg;
    wire latch_clr = wr_done && hit_st && pwdata[ST_LATCH_BIT];
    wire doze_entry = mode_next != mode_reg && mode_next inside {M_SC_DOZE, M_DC_DOZE, M_SLEEP, M_TB_DOZE};

    // Status word; unused bits read as zero.
    wire [31:0] st_word = {14'h0000, 10'(mode_reg), 5'h00, mstate_reg, tb_latch_reg};

    // Read data mux.
    wire [31:0] rd_word =
        hit_c1 ? {31'h0000_0000, stop_req_reg} :
        hit_c2 ? {27'h000_0000, ctrl2_reg} :
        hit_tbc ? {27'h000_0000, tbc_reg} :
        hit_cpu ? {30'h0000_0000, tbie_reg, ime_reg} :
        hit_st ? st_word : 32'h0000_0000;

    // APB response: one access cycle, error on unmapped address.
    // An unmapped write is dropped, since no register decodes it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
            prdata_reg <= setup ? rd_word : prdata_reg;
        end
    end

    // Software registers; request bits clear on mode entry unless that register is written then.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl2_reg <= CTRL2_RESET;
            tbc_reg <= TBC_RESET;
            stop_req_reg <= 1'b0;
            ime_reg <= 1'b0;
            tbie_reg <= 1'b0;
        end
        else
        begin
            if (wr_done && hit_c2)
                ctrl2_reg <= pwdata[4:0];
            else if (doze_entry)
            begin
                ctrl2_reg.doze <= 1'b0;
                ctrl2_reg.tg_stop <= 1'b0;
            end
            if (wr_done && hit_tbc)
                tbc_reg <= pwdata[4:0];
            if (wr_done && hit_c1)
                stop_req_reg <= pwdata[CTRL1_STOP_BIT];
            else if (enter_stop)
                stop_req_reg <= 1'b0;
            if (wr_done && hit_cpu)
            begin
                ime_reg <= pwdata[CPU_IME_BIT];
                tbie_reg <= pwdata[CPU_TBIE_BIT];
            end
        end
    end

    // Mode state, warm-up count and interrupt latch.
    // The latch set wins over a software clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= M_SC_FAST;
            warm_cnt_reg <= 12'h000;
            warm_from_fast_reg <= 1'b0;
            tben_entry_reg <= 1'b0;
            tb_latch_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            warm_cnt_reg <= (mode_reg == M_WARM && fast_tick) ? warm_cnt_reg + 12'h001 :
                            (mode_reg == M_WARM ? warm_cnt_reg : 12'h000);
            warm_from_fast_reg <= enter_stop ? fast_mode : warm_from_fast_reg;
            tben_entry_reg <= (mode_next == M_TB_DOZE && mode_reg != M_TB_DOZE) ?
                              tbc_reg.time_base_enable_bit : tben_entry_reg;
            tb_latch_reg <= latch_set | (tb_latch_reg & ~latch_clr);
        end
    end

    // Prescaler and divider chain.
    // The prescaler counts only while the fast oscillator feeds it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_reg <= '0;
            low_reg <= '0;
            high_reg <= '0;
            tap_prev_reg <= 1'b0;
        end
        else if (div_clear)
        begin
            pre_reg <= '0;
            low_reg <= '0;
            high_reg <= '0;
            tap_prev_reg <= 1'b0;
        end
        else
        begin
            pre_reg <= (fast_runs && fast_tick) ? pre_reg + 1'b1 : pre_reg;
            low_reg <= pre_carry ? low_reg + 1'b1 : low_reg;
            high_reg <= stage7_in ? high_reg + 1'b1 : high_reg;
            tap_prev_reg <= tap_now;
        end
    end

    // Machine cycle states and glitch-free source switch.
    // Warm-up has no main clock, so the source may change there freely.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mstate_reg <= 2'h0;
            use_slow_reg <= 1'b0;
            main_tick_reg <= 1'b0;
        end
        else
        begin
            mstate_reg <= main_go ? mstate_reg + 2'h1 : mstate_reg;
            use_slow_reg <= cycle_end || mode_reg == M_WARM ? want_slow : use_slow_reg;
            main_tick_reg <= main_go;
        end
    end

    // Registered run enables and wake pulses.
    // Run enables follow the next mode, so they change with the mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_run_reg <= 1'b1;
            wd_run_reg <= 1'b1;
            periph_run_reg <= 1'b1;
            fast_on_reg <= 1'b1;
            slow_on_reg <= 1'b0;
            port_reg <= 1'b1;
            irq_accept_reg <= 1'b0;
            resume_next_reg <= 1'b0;
            tb_service_reg <= 1'b0;
        end
        else
        begin
            cpu_run_reg <= next_cpu;
            wd_run_reg <= next_cpu;
            periph_run_reg <= next_periph;
            fast_on_reg <= next_fast;
            slow_on_reg <= next_slow;
            port_reg <= !next_slow;
            irq_accept_reg <= waking && ime_reg;
            resume_next_reg <= waking && !ime_reg;
            tb_service_reg <= latch_set && ime_reg && tbie_reg && tbc_reg.time_base_enable_bit;
        end
    end

    // Ports come straight from the registers above.
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign main_tick = main_tick_reg;
    assign machine_state = mstate_reg;
    assign divider_value = div_full;
    assign cpu_run = cpu_run_reg;
    assign watchdog_run = wd_run_reg;
    assign periph_run = periph_run_reg;
    assign fast_osc_on = fast_on_reg;
    assign slow_osc_on = slow_on_reg;
    assign slow_pins_as_port = port_reg;
    assign irq_accept = irq_accept_reg;
    assign resume_next = resume_next_reg;
    assign tb_irq_service = tb_service_reg;

endmodule

// ---- dv/smc_osc_model.sv ----
`timescale 1ns/1ps
// Stand-in for the two oscillators: each one gives a one-cycle tick per period while enabled.
module smc_osc_model #(
    parameter int FAST_DIV = 2,
    parameter int SLOW_DIV = 16
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Oscillator enables and ticks.
    input wire logic fast_osc_on,
    input wire logic slow_osc_on,
    output logic fast_tick,
    output logic slow_tick
);
    int fast_cnt_reg;
    int slow_cnt_reg;

    // A stopped oscillator gives no ticks at all, so a late switch-off shows up at once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_cnt_reg <= 0;
            slow_cnt_reg <= 0;
            fast_tick <= 1'b0;
            slow_tick <= 1'b0;
        end
        else
        begin
            fast_cnt_reg <= (fast_cnt_reg + 1) % FAST_DIV;
            slow_cnt_reg <= (slow_cnt_reg + 1) % SLOW_DIV;
            fast_tick <= fast_osc_on && fast_cnt_reg == 0;
            slow_tick <= slow_osc_on && slow_cnt_reg == 0;
        end
    end
endmodule

// ---- dv/smc_sva.sv ----
`timescale 1ns/1ps
// Watches the controller's ports for timing and mode relations.
module smc_sva (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Clock and run status.
    input wire logic fast_tick,
    input wire logic slow_tick,
    input wire logic irq_request,
    input wire logic main_tick,
    input wire logic [1:0] machine_state,
    input wire logic cpu_run,
    input wire logic watchdog_run,
    input wire logic periph_run,
    input wire logic slow_osc_on,
    input wire logic slow_pins_as_port,
    input wire logic irq_accept,
    input wire logic resume_next,
    input wire logic tb_irq_service
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Machine cycle states step by one or restart at zero.
    state_step_a: assert property ($changed(machine_state) |->
        machine_state == $past(machine_state) + 2'h1 || machine_state == 2'h0) else $error("bad state step");
    tick_source_a: assert property (main_tick |-> $past(fast_tick) || $past(slow_tick))
        else $error("main tick without oscillator tick");
    port_pins_a: assert property (slow_pins_as_port |-> !slow_osc_on)
        else $error("slow pins are ports while slow oscillator runs");
    doze_halt_a: assert property (!cpu_run |-> !watchdog_run)
        else $error("watchdog runs while cpu halted");
    tb_doze_a: assert property (!periph_run |-> !cpu_run && !watchdog_run)
        else $error("cpu runs while peripherals stopped");
    wake_kind_a: assert property (irq_accept |-> !resume_next)
        else $error("both wake outcomes at once");
    wake_cause_a: assert property ((irq_accept || resume_next) |-> $past(irq_request) || $past(irq_request, 2))
        else $error("wake without interrupt request");
    wake_pulse_a: assert property ((irq_accept || resume_next) |=> !irq_accept && !resume_next)
        else $error("wake pulse too long");
    tb_pulse_a: assert property (tb_irq_service |=> !tb_irq_service)
        else $error("time base service pulse too long");
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    wake_seen_c: cover property (irq_accept);
endmodule

bind smc_system_clock_mode_controller smc_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .fast_tick, .slow_tick, .irq_request, .main_tick, .machine_state, .cpu_run, .watchdog_run,
    .periph_run, .slow_osc_on, .slow_pins_as_port, .irq_accept, .resume_next, .tb_irq_service);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import smc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic irq_request = 1'b0;
    logic stop_release = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, fast_tick, slow_tick, main_tick, cpu_run, watchdog_run, periph_run;
    logic fast_osc_on, slow_osc_on, slow_pins_as_port, irq_accept, resume_next, tb_irq_service;
    logic [1:0] machine_state;
    logic [DIV_W-1:0] divider_value;
    logic [31:0] rd;
    logic err;
    logic seen;
    int fails = 0;
    int compares = 0;
    logic [31:0] ctrl_seq [6] = '{32'h0000_0003, 32'h0000_0007, 32'h0000_0006, 32'h0000_0007,
        32'h0000_0003, 32'h0000_0001};
    smc_mode_t mode_seq [6] = '{M_DC_FAST, M_SLOW_RUN_BOTH_OSC, M_SLOW_RUN_FAST_OSC_OFF, M_SLOW_RUN_BOTH_OSC, M_DC_FAST, M_SC_FAST};

    // Clock at 100 MHz.
    always #5 pclk = ~pclk;

    smc_system_clock_mode_controller #(.WARMUP_TICKS(8)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_tick(fast_tick),
        .slow_tick(slow_tick), .irq_request(irq_request), .stop_release(stop_release),
        .main_tick(main_tick), .machine_state(machine_state), .divider_value(divider_value),
        .cpu_run(cpu_run), .watchdog_run(watchdog_run), .periph_run(periph_run),
        .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on), .slow_pins_as_port(slow_pins_as_port),
        .irq_accept(irq_accept), .resume_next(resume_next), .tb_irq_service(tb_irq_service));

    smc_osc_model u_osc (.pclk(pclk), .presetn(presetn), .fast_osc_on(fast_osc_on),
        .slow_osc_on(slow_osc_on), .fast_tick(fast_tick), .slow_tick(slow_tick));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Polls the status mode field until it shows the expected mode.
    task wait_mode(input smc_mode_t m);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            n++;
        end
        while (rd[ST_MODE_LSB +: 10] !== m && n < 400);
        chk(32'(rd[ST_MODE_LSB +: 10]), 32'(m));
    endtask

    task give_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog against a hung run.
    initial
    begin
        #300_000;
        fails++;
        give_verdict();
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge pclk);
        #1;
        chk(32'(divider_value), 32'h0000_0000);
        chk(32'({cpu_run, fast_osc_on, slow_pins_as_port, slow_osc_on}), 32'h0000_000E);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_mode(M_SC_FAST);
        apb(1'b0, OFF_CTRL2, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, OFF_TBC, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk(32'(err), 32'h0000_0001);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Doze woken by an interrupt, with master enable clear and set.
        for (int ime = 0; ime < 2; ime++)
        begin
            apb(1'b1, OFF_CPU, 32'(ime));
            apb(1'b1, OFF_CTRL2, 32'h0000_0009);
            wait_mode(M_SC_DOZE);
            chk(32'({cpu_run, watchdog_run, periph_run}), 32'h0000_0001);
            @(posedge pclk);
            irq_request <= 1'b1;
            repeat (20)
            begin
                @(posedge pclk);
                #1;
                if (irq_accept === 1'b1 || resume_next === 1'b1)
                    break;
            end
            chk(32'({irq_accept, resume_next}), ime ? 32'h0000_0002 : 32'h0000_0001);
            @(posedge pclk);
            irq_request <= 1'b0;
            wait_mode(M_SC_FAST);
            apb(1'b0, OFF_CTRL2, 32'h0000_0000);
            chk(rd, 32'h0000_0001);
        end
        // Time-base-only doze, with the time base enabled and then disabled.
        for (int en = 1; en >= 0; en--)
        begin
            apb(1'b1, OFF_TBC, 32'h0000_0006 | 32'(en << TBC_EN_BIT));
            apb(1'b1, OFF_STATUS, 32'h0000_0001);
            apb(1'b1, OFF_CPU, 32'h0000_0003);
            apb(1'b1, OFF_CTRL2, 32'h0000_0011);
            seen = 1'b0;
            repeat (20)
            begin
                @(posedge pclk);
                #1;
                if (cpu_run === 1'b0)
                    break;
            end
            chk(32'({cpu_run, periph_run}), 32'h0000_0000);
            repeat (9000)
            begin
                @(posedge pclk);
                #1;
                if (tb_irq_service === 1'b1)
                    seen = 1'b1;
                if (cpu_run === 1'b1)
                    break;
            end
            repeat (10)
            begin
                @(posedge pclk);
                #1;
                if (tb_irq_service === 1'b1)
                    seen = 1'b1;
            end
            chk(32'({cpu_run, seen}), 32'(2 + en));
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            chk(32'(rd[ST_LATCH_BIT]), 32'(en));
        end
        apb(1'b1, OFF_TBC, 32'h0000_0000);
        // Dual-clock walk; the slow oscillator stays enabled while slow run is active.
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, OFF_CTRL2, ctrl_seq[i]);
            wait_mode(mode_seq[i]);
            chk(32'({fast_osc_on, slow_osc_on, slow_pins_as_port}), 32'({ctrl_seq[i][0], ctrl_seq[i][1], i == 5}));
            chk(32'(cpu_run), 32'h0000_0001);
        end
        // Dual doze and sleep, each entered from its run mode and woken by an interrupt.
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, OFF_CTRL2, k ? 32'h0000_0007 : 32'h0000_0003);
            wait_mode(k ? M_SLOW_RUN_BOTH_OSC : M_DC_FAST);
            apb(1'b1, OFF_CTRL2, k ? 32'h0000_000F : 32'h0000_000B);
            wait_mode(k ? M_SLEEP : M_DC_DOZE);
            chk(32'({cpu_run, slow_osc_on}), 32'h0000_0001);
            @(posedge pclk);
            irq_request <= 1'b1;
            wait_mode(k ? M_SLOW_RUN_BOTH_OSC : M_DC_FAST);
            @(posedge pclk);
            irq_request <= 1'b0;
        end
        apb(1'b1, OFF_CTRL2, 32'h0000_0001);
        wait_mode(M_SC_FAST);
        // Stop and warm-up clear the timing generator.
        apb(1'b1, OFF_CTRL1, 32'h0000_0001);
        wait_mode(M_STOP);
        chk(32'(divider_value), 32'h0000_0000);
        @(posedge pclk);
        stop_release <= 1'b1;
        wait_mode(M_SC_FAST);
        chk(32'(divider_value[DIV_W-1:LOW_W]), 32'h0000_0000);
        @(posedge pclk);
        stop_release <= 1'b0;
        give_verdict();
    end
endmodule
